// >>> mch_pkg.sv
// Purpose: constants shared by the motor command handler and its helpers
// Assumes: commands arrive as one-cycle strobes from an already decoded host port
// Notes: variable offsets are the byte offsets of the status variable space
// How it works
// - keep signed 16-bit previous-period duty cycle, range -600 to 600
// - previous duty is the one in use while raw current was sampled
// - consecutive chopping period count, 8 bits, saturates at 255
// - total chopping period count since last clear, 8 bits
// - set-target value means duty, speed or position per feedback mode
// - set-target value 0..4095; serial input mode copies it to input and target
// - set-target clears awaiting flag, restarts timeout, cancels both force modes
// - stop-motor sets awaiting flag and restarts the serial timeout
// - after stop, ramp duty to zero under decel limit unless hard stop
// - at zero duty after stop, brake or coast per configuration
// - forced duty target -600..600 replaces computed target until cancelled
// - forced-target command clears awaiting flag and restarts timeout
// - integral held at zero while forced target is in effect
// - forced target still gets error handling and all motor limits
// - forced target mode ends on set-target, force duty, stop or reinit
// - motor commands on all interfaces; eeprom, reinit, bootloader USB only
// - forced duty applies at once, max duty only, ignores input/feedback errors
// - on variable read with clear, copy data first then zero occurrence count
package mch_pkg;
   localparam logic [7:0] MCH_OFF_PREV_DUTY = 8'h31;
   localparam logic [7:0] MCH_OFF_CHOP_RUN = 8'h33;
   localparam logic [7:0] MCH_OFF_CHOP_TALLY = 8'h34;
   localparam logic signed [15:0] MCH_DUTY_MAX = 16'sh0258;
   localparam logic signed [15:0] MCH_DUTY_MIN = -16'sh0258;
   localparam logic [11:0] MCH_TARGET_MAX = 12'hFFF;
   localparam logic [7:0] MCH_COUNT_MAX = 8'hFF;
   localparam logic signed [15:0] MCH_DUTY_RST = 16'sh0000;
   localparam logic [15:0] MCH_TARGET_RST = 16'h0800;
   // serial timeout expressed in PID periods
   localparam logic [15:0] MCH_TIMEOUT_RST = 16'h0000;
   localparam logic [15:0] MCH_DECEL_STEP_RST = 16'h0000;
   // host interface codes
   localparam logic [1:0] MCH_IF_SERIAL = 2'h0;
   localparam logic [1:0] MCH_IF_I2C = 2'h1;
   localparam logic [1:0] MCH_IF_USB = 2'h2;
   // input mode code for serial control
   localparam logic [1:0] MCH_IN_SERIAL = 2'h0;
   typedef enum logic [1:0] {
      MCH_RUN_type_RUN,
      MCH_RUN_type_RAMP,
      MCH_RUN_type_HELD
   } mch_run_type;
endpackage : mch_pkg

// >>> mch_sat_count.sv
// Purpose: 8-bit saturating period counter
// Assumes: tick pulses once per pid period
// Notes: clear and count in one cycle: the clear wins, the counted period is lost
module mch_sat_count
   import mch_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // control
   input wire logic tick_i,
   input wire logic hit_i,
   input wire logic zero_on_miss_i,
   input wire logic clear_i,
   // count
   output logic [7:0] count_o
);
   logic [7:0] next_count;
   wire logic at_max = (count_o == MCH_COUNT_MAX);
   // saturate instead of wrapping so long runs stay visible
   always_comb begin
      next_count = count_o;
      if (clear_i) begin
         next_count = 8'h00;
      end else if (tick_i && hit_i && !at_max) begin
         next_count = count_o + 8'h01;
      end else if (tick_i && !hit_i && zero_on_miss_i) begin
         next_count = 8'h00;
      end
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) count_o <= 8'h00;
      else count_o <= next_count;
   end
endmodule : mch_sat_count

// >>> mch_duty_limit.sv
// Purpose: clamp a signed duty request to a symmetric limit
// Assumes: limit is positive and no larger than full scale
// Notes: purely combinational
module mch_duty_limit
   import mch_pkg::*;
(
   // request and limit
   input wire logic signed [15:0] req_i,
   input wire logic signed [15:0] limit_i,
   // result
   output logic signed [15:0] duty_o
);
   wire logic signed [15:0] lim_pos = (limit_i > MCH_DUTY_MAX) ? MCH_DUTY_MAX : limit_i;
   wire logic signed [15:0] lim_neg = -lim_pos;
   assign duty_o = (req_i > lim_pos) ? lim_pos : ((req_i < lim_neg) ? lim_neg : req_i);
endmodule : mch_duty_limit

// >>> mch_motor_cmd.sv
// Purpose: motor command handling and per-period status variables
// Assumes: commands are one-cycle strobes decoded upstream, pid_tick marks period end
// Notes: the pid algorithm is outside; it supplies its computed duty target here
module mch_motor_cmd
   import mch_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // command strobes with their interface and arguments
   input wire logic [1:0] cmd_if_i,
   input wire logic cmd_set_target_i,
   input wire logic [15:0] cmd_target_i,
   input wire logic cmd_stop_i,
   input wire logic cmd_force_target_i,
   input wire logic cmd_force_duty_i,
   input wire logic signed [15:0] cmd_duty_i,
   input wire logic cmd_reinit_i,
   input wire logic cmd_eeprom_write_i,
   input wire logic cmd_bootloader_i,
   // variable read
   input wire logic var_read_i,
   input wire logic [7:0] var_offset_i,
   input wire logic var_clear_tally_i,
   // configuration
   input wire logic [1:0] input_mode_i,
   input wire logic awaiting_hard_stop_i,
   input wire logic brake_at_zero_i,
   input wire logic [15:0] decel_step_i,
   input wire logic signed [15:0] max_duty_i,
   input wire logic signed [15:0] limited_max_duty_i,
   input wire logic [15:0] timeout_periods_i,
   // pid side
   input wire logic pid_tick_i,
   input wire logic signed [15:0] pid_duty_target_i,
   input wire logic other_error_i,
   input wire logic input_fb_error_i,
   // current chopping level from the current sense hardware (asynchronous)
   input wire logic chop_active_i,
   // motor drive results
   output logic signed [15:0] duty_o,
   output logic signed [15:0] duty_target_o,
   output logic brake_o,
   output logic integral_zero_o,
   // status
   output logic awaiting_cmd_o,
   output logic timeout_error_o,
   output logic [15:0] input_var_o,
   output logic [15:0] target_var_o,
   output logic force_target_o,
   output logic force_duty_o,
   output logic eeprom_write_o,
   output logic bootloader_o,
   output logic reinit_o,
   output logic [15:0] read_data_o,
   output logic read_valid_o
);
   logic chop_meta;
   logic chop_sync;
   logic chop_seen;
   logic signed [15:0] prev_duty;
   logic signed [15:0] force_value;
   logic [15:0] timeout_cnt;
   logic [7:0] chop_run;
   logic [7:0] chop_tally;
   mch_run_type run_state;
   mch_run_type next_run_state;
   logic signed [15:0] next_duty;
   logic signed [15:0] normal_duty;
   logic signed [15:0] forced_duty;

   // usb-only commands are dropped when they arrive elsewhere
   wire logic from_usb = (cmd_if_i == MCH_IF_USB);
   wire logic reinit_ok = cmd_reinit_i && from_usb;
   wire logic eeprom_ok = cmd_eeprom_write_i && from_usb;
   wire logic boot_ok = cmd_bootloader_i && from_usb;
   wire logic target_ok = (cmd_target_i <= {4'h0, MCH_TARGET_MAX});
   wire logic set_ok = cmd_set_target_i && target_ok;
   wire logic duty_arg_ok = (cmd_duty_i >= MCH_DUTY_MIN) && (cmd_duty_i <= MCH_DUTY_MAX);
   wire logic ftgt_ok = cmd_force_target_i && duty_arg_ok;
   wire logic fduty_ok = cmd_force_duty_i && duty_arg_ok;
   // stop, reinit and set outrank either force
   wire logic force_end = set_ok || cmd_stop_i || reinit_ok;
   wire logic ftgt_take = ftgt_ok && !force_end;
   wire logic restart_timer = set_ok || cmd_stop_i || ftgt_ok || fduty_ok;
   wire logic timed_out = (timeout_periods_i != 16'h0000) && (timeout_cnt >= timeout_periods_i);
   // forced target still obeys errors; forced duty ignores input and feedback errors
   wire logic halted = awaiting_cmd_o || timeout_error_o || other_error_i
      || input_fb_error_i;
   wire logic halted_force = awaiting_cmd_o || timeout_error_o || other_error_i;
   wire logic signed [15:0] target_sel = force_target_o ? force_value : pid_duty_target_i;
   wire logic signed [15:0] mag = duty_o[15] ? -duty_o : duty_o;
   wire logic signed [15:0] step = $signed(decel_step_i);
   wire logic no_decel = (decel_step_i == 16'h0000) || awaiting_hard_stop_i;
   wire logic near_zero = no_decel || (mag <= step);
   wire logic signed [15:0] ramp_duty = near_zero ? 16'sh0000 :
      (duty_o[15] ? duty_o + step : duty_o - step);
   wire logic [7:0] next_read_byte_hi;
   wire logic read_prev = (var_offset_i == MCH_OFF_PREV_DUTY);
   wire logic read_run = (var_offset_i == MCH_OFF_CHOP_RUN);
   wire logic read_tally = (var_offset_i == MCH_OFF_CHOP_TALLY);
   // unimplemented offsets read as zero
   wire logic [15:0] read_mux = read_prev ? prev_duty :
      (read_run ? {8'h00, chop_run} : (read_tally ? {8'h00, chop_tally} : 16'h0000));
   assign next_read_byte_hi = read_mux[15:8];
   // the clear lands one cycle after the read data is captured
   logic clear_pending;

   // forced target gets all normal limits
   mch_duty_limit u_lim_norm (
      .req_i(target_sel),
      .limit_i(limited_max_duty_i),
      .duty_o(normal_duty)
   );
   // forced duty only respects the maximum duty cycle
   mch_duty_limit u_lim_force (
      .req_i(force_value),
      .limit_i(max_duty_i),
      .duty_o(forced_duty)
   );

   mch_sat_count u_run (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(pid_tick_i),
      .hit_i(chop_seen),
      .zero_on_miss_i(1'b1),
      .clear_i(1'b0),
      .count_o(chop_run)
   );
   mch_sat_count u_tally (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(pid_tick_i),
      .hit_i(chop_seen),
      .zero_on_miss_i(1'b0),
      .clear_i(clear_pending),
      .count_o(chop_tally)
   );

   // chopping is a pin level, so synchronise before use
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chop_meta <= 1'b0;
         chop_sync <= 1'b0;
      end else begin
         chop_meta <= chop_active_i;
         chop_sync <= chop_meta;
      end
   end

   // remember any chopping within the period, reloaded from the synchronised level at the period end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) chop_seen <= 1'b0;
      else if (pid_tick_i) chop_seen <= chop_sync;
      else if (chop_sync) chop_seen <= 1'b1;
   end

   // stop ramp: running, ramping down, held at zero
   always_comb begin
      next_run_state = run_state;
      unique case (run_state)
         MCH_RUN_type_RUN: if (halted && !force_duty_o) next_run_state = MCH_RUN_type_RAMP;
         MCH_RUN_type_RAMP: begin
            if (!halted || force_duty_o) next_run_state = MCH_RUN_type_RUN;
            else if (pid_tick_i && ramp_duty == 16'sh0000) next_run_state = MCH_RUN_type_HELD;
         end
         MCH_RUN_type_HELD: if (!halted || force_duty_o) next_run_state = MCH_RUN_type_RUN;
      endcase
   end

   // next duty: forced duty acts at once, the rest only at the period boundary
   always_comb begin
      next_duty = duty_o;
      if (force_duty_o) begin
         next_duty = halted_force ? 16'sh0000 : forced_duty;
      end else if (pid_tick_i) begin
         if (run_state == MCH_RUN_type_RUN && !halted) next_duty = normal_duty;
         else next_duty = ramp_duty;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) run_state <= MCH_RUN_type_RUN;
      else run_state <= next_run_state;
   end

   // duty registers; previous duty latched before the new one is applied
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         duty_o <= MCH_DUTY_RST;
         prev_duty <= MCH_DUTY_RST;
      end else begin
         duty_o <= next_duty;
         if (pid_tick_i) prev_duty <= duty_o;
      end
   end

   // brake or coast once held at zero after a stop
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) brake_o <= 1'b0;
      else brake_o <= (next_run_state == MCH_RUN_type_HELD) && brake_at_zero_i;
   end

   // force modes; each command ends the other force mode
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         force_target_o <= 1'b0;
         force_duty_o <= 1'b0;
         force_value <= MCH_DUTY_RST;
      end else begin
         if (force_end) begin
            force_target_o <= 1'b0;
            force_duty_o <= 1'b0;
         end else if (ftgt_ok) begin
            force_target_o <= 1'b1;
            force_duty_o <= 1'b0;
            force_value <= cmd_duty_i;
         end else if (fduty_ok) begin
            force_duty_o <= 1'b1;
            force_target_o <= 1'b0;
            force_value <= cmd_duty_i;
         end
      end
   end

   // integral held at zero in either force mode
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) integral_zero_o <= 1'b0;
      else integral_zero_o <= (force_target_o || force_duty_o || ftgt_ok || fduty_ok)
         && !force_end;
   end

   // awaiting flag comes up set so the motor waits for a first command
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) awaiting_cmd_o <= 1'b1;
      else if (cmd_stop_i || reinit_ok) awaiting_cmd_o <= 1'b1;
      else if (set_ok || ftgt_ok || fduty_ok) awaiting_cmd_o <= 1'b0;
   end

   // serial timeout counts pid periods; any motor command restarts it
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timeout_cnt <= MCH_TIMEOUT_RST;
         timeout_error_o <= 1'b0;
      end else if (restart_timer) begin
         timeout_cnt <= MCH_TIMEOUT_RST;
         timeout_error_o <= 1'b0;
      end else if (pid_tick_i) begin
         if (!timed_out) timeout_cnt <= timeout_cnt + 16'h0001;
         timeout_error_o <= timed_out;
      end
   end

   // serial input mode copies the target; its meaning depends on feedback mode
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         input_var_o <= MCH_TARGET_RST;
         target_var_o <= MCH_TARGET_RST;
      end else if (set_ok && input_mode_i == MCH_IN_SERIAL) begin
         input_var_o <= cmd_target_i;
         target_var_o <= cmd_target_i;
      end
   end

   // target drive value follows the selected source each period
   // a taken force target shows at once
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         duty_target_o <= MCH_DUTY_RST;
      end else if (ftgt_take) begin
         duty_target_o <= cmd_duty_i;
      end else if (pid_tick_i) begin
         duty_target_o <= target_sel;
      end
   end

   // usb-only command pulses
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eeprom_write_o <= 1'b0;
         bootloader_o <= 1'b0;
         reinit_o <= 1'b0;
      end else begin
         eeprom_write_o <= eeprom_ok;
         bootloader_o <= boot_ok;
         reinit_o <= reinit_ok;
      end
   end

   // read data captured first; the tally clear follows a cycle later
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_data_o <= 16'h0000;
         read_valid_o <= 1'b0;
         clear_pending <= 1'b0;
      end else begin
         read_valid_o <= var_read_i;
         clear_pending <= var_read_i && var_clear_tally_i;
         if (var_read_i) read_data_o <= {next_read_byte_hi, read_mux[7:0]};
      end
   end
endmodule : mch_motor_cmd

// >>> mch_motor_cmd_props.sv
// Purpose: port-level checks for the motor command handler
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound below to every mch_motor_cmd instance
module mch_motor_cmd_props
   import mch_pkg::*;
(
   // clock, reset and watched inputs
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] cmd_if_i,
   input wire logic cmd_set_target_i,
   input wire logic [15:0] cmd_target_i,
   input wire logic cmd_stop_i,
   input wire logic cmd_force_target_i,
   input wire logic cmd_force_duty_i,
   input wire logic signed [15:0] cmd_duty_i,
   input wire logic cmd_reinit_i,
   input wire logic var_read_i,
   input wire logic [7:0] var_offset_i,
   input wire logic var_clear_tally_i,
   input wire logic [1:0] input_mode_i,
   input wire logic signed [15:0] max_duty_i,
   input wire logic other_error_i,
   input wire logic pid_tick_i,
   // watched outputs
   input wire logic signed [15:0] duty_o,
   input wire logic integral_zero_o,
   input wire logic awaiting_cmd_o,
   input wire logic [15:0] target_var_o,
   input wire logic force_target_o,
   input wire logic force_duty_o,
   input wire logic reinit_o,
   input wire logic [15:0] read_data_o,
   input wire logic read_valid_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // commands that outrank both force modes when they share a cycle
   wire logic hi_cmd = cmd_stop_i | cmd_set_target_i | (cmd_reinit_i & (cmd_if_i == MCH_IF_USB));
   wire logic duty_ok = (cmd_duty_i <= MCH_DUTY_MAX) && (cmd_duty_i >= MCH_DUTY_MIN);
   // command side effects, one cycle after the strobe
   property p_set_clears;
      cmd_set_target_i && cmd_target_i <= 16'h0FFF && !cmd_stop_i && !cmd_reinit_i
         |=> !awaiting_cmd_o && !force_target_o && !force_duty_o;
   endproperty
   a_set_clears: assert property (p_set_clears) else $error("set target side effects");
   property p_set_copy;
      cmd_set_target_i && input_mode_i == MCH_IN_SERIAL && cmd_target_i <= 16'h0FFF
         |=> target_var_o == $past(cmd_target_i);
   endproperty
   a_set_copy: assert property (p_set_copy) else $error("target not copied");
   property p_stop;
      cmd_stop_i && !cmd_set_target_i |=> awaiting_cmd_o && !force_target_o;
   endproperty
   a_stop: assert property (p_stop) else $error("stop side effects");
   property p_force_tgt;
      cmd_force_target_i && !hi_cmd && duty_ok |=> force_target_o && !awaiting_cmd_o;
   endproperty
   a_force_tgt: assert property (p_force_tgt) else $error("force target entry");
   property p_integral; force_target_o |-> integral_zero_o; endproperty
   a_integral: assert property (p_integral) else $error("integral not held");
   // forced duty shows on the duty output with only the maximum clamp
   property p_force_duty;
      cmd_force_duty_i && !hi_cmd && !cmd_force_target_i && duty_ok && !other_error_i
         && max_duty_i == MCH_DUTY_MAX |=> force_duty_o ##1 duty_o == $past(cmd_duty_i, 2);
   endproperty
   a_force_duty: assert property (p_force_duty) else $error("forced duty wrong");
   property p_reinit_usb; cmd_reinit_i && cmd_if_i != MCH_IF_USB |=> !reinit_o; endproperty
   a_reinit_usb: assert property (p_reinit_usb) else $error("reinit off usb");
   // counters sit in the low byte of a read answer
   property p_read_byte;
      var_read_i && (var_offset_i == MCH_OFF_CHOP_RUN || var_offset_i == MCH_OFF_CHOP_TALLY)
         |=> read_valid_o && read_data_o[15:8] == 8'h00;
   endproperty
   a_read_byte: assert property (p_read_byte) else $error("count read wrong");
   property p_tally_clear;
      (var_read_i && var_clear_tally_i && var_offset_i == MCH_OFF_CHOP_TALLY && !pid_tick_i)
         ##1 !pid_tick_i ##1 (var_read_i && var_offset_i == MCH_OFF_CHOP_TALLY && !pid_tick_i)
         |=> read_data_o == 16'h0000;
   endproperty
   a_tally_clear: assert property (p_tally_clear) else $error("tally not cleared");
   // main scenarios reached
   c_force: cover property (force_target_o && integral_zero_o);
   c_sat: cover property (read_valid_o && read_data_o == 16'h00FF);
   c_ramp: cover property (awaiting_cmd_o && duty_o != 16'sh0000 && $past(pid_tick_i));
endmodule : mch_motor_cmd_props

bind mch_motor_cmd mch_motor_cmd_props mch_motor_cmd_props_inst (.*);

// >>> mch_host_model.sv
// Purpose: host-side command source for the motor command handler
// Assumes: the bench changes go_i, op_i and arg_i at the falling edge
// Notes: arguments stay in range unless bad_i asks for a refusal case
module mch_host_model
   import mch_pkg::*;
(
   // request from the bench
   input wire logic go_i,
   input wire logic bad_i,
   input wire logic [2:0] op_i,
   input wire logic signed [15:0] arg_i,
   // strobes: set, stop, force target, force duty, reinit, eeprom, bootloader
   output logic [6:0] strobe_o,
   output logic [15:0] target_o,
   output logic signed [15:0] duty_o
);
   // one strobe per op code 0 to 6 while a request stands; op code 7 gives none
   assign strobe_o = go_i ? (7'h01 << op_i) : 7'h00;
   // a well-behaved host never leaves the documented ranges
   assign target_o = (bad_i || arg_i[15:12] == 4'h0) ? arg_i : {4'h0, MCH_TARGET_MAX};
   assign duty_o = (bad_i || (arg_i <= MCH_DUTY_MAX && arg_i >= MCH_DUTY_MIN)) ? arg_i
      : 16'sh0000;
endmodule : mch_host_model

// >>> mch_motor_cmd_tb_top.sv
// Purpose: self-checking bench for the motor command handler
// Assumes: inputs change on the falling edge, outputs read once settled
// Notes: read answers are noted in a queue and compared when read_valid_o shows
module mch_motor_cmd_tb_top
   import mch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, go = 1'b0, bad = 1'b0, var_read_i = 1'b0;
   logic var_clear_tally_i = 1'b0, pid_tick_i = 1'b0, chop_active_i = 1'b0;
   logic brake_at_zero_i = 1'b0, awaiting_hard_stop_i = 1'b0, other_error_i = 1'b0;
   logic input_fb_error_i = 1'b0;
   logic [1:0] cmd_if_i = 2'h0, input_mode_i = 2'h0;
   logic [2:0] op = 3'h0;
   logic [6:0] strobe;
   logic [7:0] var_offset_i = 8'h00;
   logic [15:0] decel_step_i = 16'h0000, timeout_periods_i = 16'h0000, cmd_target, v;
   logic signed [15:0] arg = 16'sh0000, max_duty_i = MCH_DUTY_MAX,
      limited_max_duty_i = MCH_DUTY_MAX;
   logic signed [15:0] pid_duty_target_i = 16'sh0000, cmd_duty, a, duty_o, duty_target_o;
   logic brake_o, integral_zero_o, awaiting_cmd_o, timeout_error_o, force_target_o;
   logic force_duty_o, eeprom_write_o, bootloader_o, reinit_o, read_valid_o;
   logic [15:0] input_var_o, target_var_o, read_data_o;
   logic [15:0] expq[$];
   logic [2:0] ends [4] = '{3'd0, 3'd3, 3'd1, 3'd4};
   int fails = 0, compares = 0, cycles = 0, seed;

   mch_host_model mch_host_model_inst (.go_i(go), .bad_i(bad), .op_i(op), .arg_i(arg),
      .strobe_o(strobe), .target_o(cmd_target), .duty_o(cmd_duty));
   mch_motor_cmd mch_motor_cmd_inst (.ref_clk_i, .rst_n_i, .cmd_if_i,
      .cmd_set_target_i(strobe[0]), .cmd_target_i(cmd_target), .cmd_stop_i(strobe[1]),
      .cmd_force_target_i(strobe[2]), .cmd_force_duty_i(strobe[3]), .cmd_duty_i(cmd_duty),
      .cmd_reinit_i(strobe[4]), .cmd_eeprom_write_i(strobe[5]), .cmd_bootloader_i(strobe[6]),
      .var_read_i, .var_offset_i, .var_clear_tally_i, .input_mode_i, .awaiting_hard_stop_i,
      .brake_at_zero_i, .decel_step_i, .max_duty_i, .limited_max_duty_i, .timeout_periods_i,
      .pid_tick_i, .pid_duty_target_i, .other_error_i, .input_fb_error_i, .chop_active_i,
      .duty_o, .duty_target_o, .brake_o, .integral_zero_o, .awaiting_cmd_o, .timeout_error_o,
      .input_var_o, .target_var_o, .force_target_o, .force_duty_o, .eeprom_write_o,
      .bootloader_o, .reinit_o, .read_data_o, .read_valid_o);

   // 10 MHz clock
   always #50 ref_clk_i = ~ref_clk_i;

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic close_out;
      if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // one command: strobe held for exactly one rising edge
   task automatic cmd(input logic [2:0] o, input logic signed [15:0] x, input logic [1:0] itf);
      @(negedge ref_clk_i);
      op = o;
      arg = x;
      cmd_if_i = itf;
      go = 1'b1;
      @(negedge ref_clk_i);
      go = 1'b0;
   endtask : cmd

   // variable read; the answer is noted for the watcher
   task automatic rd(input logic [7:0] off, input logic clr, input logic [15:0] exp);
      @(negedge ref_clk_i);
      var_read_i = 1'b1;
      var_offset_i = off;
      var_clear_tally_i = clr;
      expq.push_back(exp);
      @(negedge ref_clk_i);
      var_read_i = 1'b0;
      var_clear_tally_i = 1'b0;
   endtask : rd

   // one pid period; chop drops early so the synchroniser settles inside the period
   task automatic tick(input logic c);
      chop_active_i = c;
      repeat (3) @(negedge ref_clk_i);
      chop_active_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      pid_tick_i = 1'b1;
      pid_duty_target_i = 16'($random(seed) % 601);
      @(negedge ref_clk_i);
      pid_tick_i = 1'b0;
   endtask : tick

   // read watcher: oldest note against each answer
   always @(negedge ref_clk_i) begin
      if (read_valid_o === 1'b1) begin
         if (expq.size() == 0) check("read_extra", 16'h0001, 16'h0000);
         else check("read_data", read_data_o, expq.pop_front());
      end
   end

   // hang guard, well above the expected run of about 2,000 cycles
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         close_out();
      end
   end

   initial begin
      seed = 32'hA3390BBE;
      repeat (4) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      // set target over every interface, top value first
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 16'h0FFF : (16'($random(seed)) & 16'h0FFF);
         cmd(3'd0, v, 2'(i % 3));
         check("target_var", target_var_o, v);
         check("input_var", input_var_o, v);
         check("awaiting", awaiting_cmd_o, 1'b0);
      end
      input_mode_i = 2'h1;
      cmd(3'd0, 16'sh0123, MCH_IF_SERIAL);
      check("target_kept", target_var_o, v);
      input_mode_i = 2'h0;
      bad = 1'b1;
      cmd(3'd0, 16'sh1000, MCH_IF_SERIAL);
      check("target_refused", target_var_o, v);
      bad = 1'b0;
      // force target, then each command that ends it
      for (int i = 0; i < 4; i++) begin
         a = 16'($random(seed) % 601);
         cmd(3'd2, a, MCH_IF_I2C);
         check("duty_target", duty_target_o, a);
         check("integral_zero", integral_zero_o, 1'b1);
         cmd(ends[i], 16'sh0000, MCH_IF_USB);
         check("force_end", force_target_o, 1'b0);
      end
      // usb-only commands from every interface
      for (int i = 0; i < 3; i++) begin
         cmd(3'd5, 16'sh0000, 2'(i));
         check("eeprom", eeprom_write_o, i == 2);
         cmd(3'd6, 16'sh0000, 2'(i));
         check("boot", bootloader_o, i == 2);
         cmd(3'd4, 16'sh0000, 2'(i));
         check("reinit", reinit_o, i == 2);
      end
      // stop with deceleration limit, then hard stop
      decel_step_i = 16'h0064;
      brake_at_zero_i = 1'($random(seed));
      input_fb_error_i = 1'b1;
      cmd(3'd3, 16'sd300, MCH_IF_SERIAL);
      @(negedge ref_clk_i);
      check("forced_duty", duty_o, 16'sd300);
      input_fb_error_i = 1'b0;
      cmd(3'd1, 16'sh0000, MCH_IF_I2C);
      check("awaiting", awaiting_cmd_o, 1'b1);
      tick(1'b0);
      check("ramp", duty_o, 16'sd200);
      rd(MCH_OFF_PREV_DUTY, 1'b0, 16'sd300);
      repeat (2) tick(1'b0);
      @(negedge ref_clk_i);
      check("ramp_end", duty_o, 16'sh0000);
      check("brake", brake_o, brake_at_zero_i);
      awaiting_hard_stop_i = 1'b1;
      cmd(3'd3, -16'sd400, MCH_IF_USB);
      cmd(3'd1, 16'sh0000, MCH_IF_USB);
      tick(1'b0);
      check("hard_stop", duty_o, 16'sh0000);
      awaiting_hard_stop_i = 1'b0;
      timeout_periods_i = 16'h0002;
      cmd(3'd0, 16'sh0100, MCH_IF_SERIAL);
      repeat (3) tick(1'b0);
      check("timeout", timeout_error_o, 1'b1);
      cmd(3'd1, 16'sh0000, MCH_IF_SERIAL);
      check("timeout_clr", timeout_error_o, 1'b0);
      // chopping counters: run, break, clear, saturation
      repeat (3) tick(1'b1);
      rd(MCH_OFF_CHOP_RUN, 1'b0, 16'h0003);
      tick(1'b0);
      rd(MCH_OFF_CHOP_RUN, 1'b0, 16'h0000);
      rd(MCH_OFF_CHOP_TALLY, 1'b0, 16'h0003);
      tick(1'b1);
      rd(MCH_OFF_CHOP_TALLY, 1'b1, 16'h0004);
      rd(MCH_OFF_CHOP_TALLY, 1'b0, 16'h0000);
      repeat (260) tick(1'b1);
      rd(MCH_OFF_CHOP_RUN, 1'b0, 16'h00FF);
      rd(MCH_OFF_CHOP_TALLY, 1'b0, 16'h00FF);
      repeat (3) @(negedge ref_clk_i);
      close_out();
   end
endmodule : mch_motor_cmd_tb_top
